// File: vias_assertions.sv
// vias_assertions: port-level checks bound into vias_top.
// assumes config byte 9 sits in settings[79:72], one cycle behind storage.
`timescale 1ns/1ps
module vias_assertions
    import vias_pkg::*;
#(
    parameter int NREG = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // activity inputs
    input wire logic conv_activity,
    input wire logic slice_video_in_a,
    input wire logic slice_video_in_b,
    input wire logic sleep_mode,
    // outputs watched
    input wire logic mux_sel_b,
    input wire logic [NREG*8-1:0] settings,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic irq_n_o,
    input wire logic irq_n_oe
);
    // config bits taken from the register image
    wire auto_on = settings[73];
    wire man_b = settings[72];
    wire irq_mask = settings[79];
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_irq_drain: assert property (irq_n_o == 1'b0)
        else $error("interrupt pin driven high");
    chk_sda_drain: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    // the reset check must not be switched off by the reset itself
    chk_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> !irq_n_oe && !mux_sel_b && !sda_oe) else $error("outputs active in reset");
    chk_mask_quiet: assert property ($rose(irq_n_oe) |-> !irq_mask)
        else $error("interrupt while masked");
    chk_manual_mux: assert property (
        (!auto_on && $stable(settings[73:72]))[*3] |-> mux_sel_b == man_b)
        else $error("mux ignores manual choice");
    chk_auto_stay: assert property (
        (auto_on && mux_sel_b && conv_activity && !sleep_mode)[*4] |=> mux_sel_b)
        else $error("left input two while active");
    chk_auto_back: assert property (
        (auto_on && mux_sel_b && !conv_activity && !sleep_mode)[*2] |-> ##[1:6] !mux_sel_b)
        else $error("stuck on quiet input two");
    chk_auto_to_b: assert property (
        (auto_on && !mux_sel_b && !conv_activity && slice_video_in_b && !sleep_mode)[*8]
        |-> ##[0:4] mux_sel_b) else $error("input two not picked");
    chk_auto_none: assert property (
        (auto_on && !conv_activity && !slice_video_in_a && !slice_video_in_b && !sleep_mode)[*8]
        |-> !mux_sel_b) else $error("input one not picked when idle");
    chk_sleep_pick: assert property (
        (auto_on && sleep_mode && slice_video_in_b && !slice_video_in_a && !mux_sel_b)[*8]
        |-> ##[0:4] mux_sel_b) else $error("sleep pick wrong");
    // main scenarios reached
    cov_irq: cover property ($rose(irq_n_oe));
    cov_auto_b: cover property (auto_on && $rose(mux_sel_b));
    cov_ack: cover property ($rose(sda_oe));
endmodule : vias_assertions
bind vias_top vias_assertions #(.NREG(NREG)) i_chk (
    .clk, .sys_rst, .conv_activity, .slice_video_in_a, .slice_video_in_b, .sleep_mode,
    .mux_sel_b, .settings, .sda_o, .sda_oe, .irq_n_o, .irq_n_oe
);

// File: vias_defs.svh
// vias_defs.svh: offsets, field positions, reset values and slave addresses
// for the video input activity and select block; included by the testbench
// and by the design, definitions only.
`ifndef VIAS_DEFS_SVH
`define VIAS_DEFS_SVH
`define VIAS_REG_STATUS 4'h0
`define VIAS_REG_INPUT_CHOICE_FIELD 4'h9
`define VIAS_STAT_ACT_A 0
`define VIAS_STAT_ACT_B 1
`define VIAS_STAT_SEL_B 2
`define VIAS_CFG_CHOICE 0
`define VIAS_CFG_AUTO 1
`define VIAS_CFG_IRQ_MASK 7
`define VIAS_CFG_RESET 8'h00
`define VIAS_REG_RESET 8'h00
`define VIAS_ADDR_STRAP_HI 7'h20
`define VIAS_ADDR_STRAP_LO 7'h21
`define VIAS_ADDR_STRAP_SDA 7'h22
`define VIAS_SYNC_STAGES 3
`endif

// File: vias_i2c_host.sv
// vias_i2c_host: two-wire bus master for the register port.
// assumes the data line is resolved with a pull-up outside; clock never stretched.
`timescale 1ns/1ps
module vias_i2c_host (
    // pacing clock
    input wire logic clk,
    // bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_dn
);
    initial begin
        scl = 1'b1;
        sda_dn = 1'b0;
    end
    // half bit of 10 clocks keeps both phases above the slave's filter
    task automatic hp();
        repeat (10) @(negedge clk);
    endtask : hp
    // data set while clock low, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_dn = !b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        scl = 1'b0;
        repeat (3) @(negedge clk); // hold so data never moves with the clock fall
    endtask : bit_io
    // also serves as repeated start
    task automatic start();
        sda_dn = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_dn = 1'b1;
        hp();
        scl = 1'b0;
        repeat (3) @(negedge clk);
    endtask : start
    task automatic stop();
        sda_dn = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_dn = 1'b0;
        hp();
    endtask : stop
    // eight bits msb first, then the ninth; q and ack are what the line showed
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
                        output logic ack);
        for (int k = 7; k >= 0; k--) bit_io(d[k], q[k]);
        bit_io(nine, ack);
    endtask : xfer
endmodule : vias_i2c_host

// File: vias_pkg.sv
// vias_pkg: types shared by the activity/select block.
// assumes vias_defs.svh on the include path.
package vias_pkg;
    // activity and selection as shown in the status byte
    typedef struct packed {
        logic sel_b;
        logic act_b;
        logic act_a;
    } vias_status_type;
    // pins that cross into the clock domain
    typedef struct packed {
        logic strap;
        logic slice_b;
        logic slice_a;
        logic scl;
        logic sda;
    } vias_pins_type;
    // automatic pick: one bit, gray by nature
    typedef enum logic {
        VIAS_PICK_A = 1'b0,
        VIAS_PICK_B = 1'b1
    } vias_pick_type;
    // serial slave states, gray along address, pointer, write path
    typedef enum logic [3:0] {
        VIAS_IDLE = 4'h0,
        VIAS_ADDR = 4'h1,
        VIAS_AACK = 4'h3,
        VIAS_PTR = 4'h2,
        VIAS_PACK = 4'h6,
        VIAS_WR = 4'h7,
        VIAS_WACK = 4'h5,
        VIAS_RD = 4'hC,
        VIAS_RACK = 4'hD
    } vias_i2c_type;
endpackage : vias_pkg

// File: vias_top.sv
// vias_top: input activity watch, input choice and serial register slave.
// assumes one 40 MHz clock, slicer/serial/strap pins asynchronous to it,
// and the converter-based activity flag already on this clock.
`timescale 1ns/1ps
`include "vias_defs.svh"
module vias_top
    import vias_pkg::*;
#(
    parameter int NREG = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial register port
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic slave_addr_strap,
    // activity sources
    input wire logic conv_activity,
    input wire logic slice_video_in_a,
    input wire logic slice_video_in_b,
    input wire logic sleep_mode,
    // front-end control and settings
    output logic mux_sel_b,
    output logic [NREG*8-1:0] settings,
    // interrupt, open drain
    output logic irq_n_o,
    output logic irq_n_oe
);
    // majority of two late stages: a change counts once both agree
    function automatic logic agree(input logic s2, input logic s3, input logic f);
        agree = (s2 & s3) | (f & (s2 | s3));
    endfunction : agree

    // pin synchronisers; stage one feeds only stage two
    vias_pins_type pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_f_nxt;
    vias_pins_type pin_now;
    logic strap_prev_r;
    assign pin_now = '{strap: slave_addr_strap, slice_b: slice_video_in_b,
                       slice_a: slice_video_in_a, scl: scl_i, sda: sda_i};
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_f_nxt[i] = agree(pin_s2_r[i], pin_s3_r[i], pin_f_r[i]);
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1_r <= 5'h13;
            pin_s2_r <= 5'h13;
            pin_s3_r <= 5'h13;
            pin_f_r <= 5'h13;
            strap_prev_r <= 1'b1;
        end else begin
            pin_s1_r <= pin_now;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r <= pin_f_nxt;
            strap_prev_r <= pin_f_r.strap;
        end
    end

    // register storage and decoded config
    logic [7:0] regs_r [NREG];
    logic [7:0] regs_nxt [NREG];
    logic [7:0] cfg;
    assign cfg = regs_r[`VIAS_REG_INPUT_CHOICE_FIELD];

    // activity: the decoded input uses the converter unless asleep
    vias_pick_type pick_r, pick_nxt;
    vias_status_type stat_r, stat_nxt;
    logic sel_b_nxt;
    always_comb begin
        // both inputs evaluated every cycle
        stat_nxt.act_a = pin_f_r.slice_a;
        stat_nxt.act_b = pin_f_r.slice_b;
        if (!sleep_mode && !mux_sel_b) begin
            stat_nxt.act_a = conv_activity;
        end
        if (!sleep_mode && mux_sel_b) begin
            stat_nxt.act_b = conv_activity;
        end
        if (sleep_mode) begin
            stat_nxt.act_a = pin_f_r.slice_a;
            stat_nxt.act_b = pin_f_r.slice_b;
        end
        stat_nxt.sel_b = mux_sel_b;
        // auto pick: a reset start on input one covers both-active power-up
        pick_nxt = pick_r;
        case (pick_r)
            VIAS_PICK_A: begin
                if (stat_r.act_b && !stat_r.act_a) begin
                    pick_nxt = VIAS_PICK_B;
                end
            end
            VIAS_PICK_B: begin
                if (!stat_r.act_b) begin
                    pick_nxt = VIAS_PICK_A;
                end
            end
            default: pick_nxt = VIAS_PICK_A;
        endcase
        if (cfg[`VIAS_CFG_AUTO]) begin
            sel_b_nxt = (pick_nxt == VIAS_PICK_B);
        end else begin
            sel_b_nxt = cfg[`VIAS_CFG_CHOICE];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pick_r <= VIAS_PICK_A;
            stat_r <= 3'h0;
            mux_sel_b <= 1'b0;
        end else begin
            pick_r <= pick_nxt;
            stat_r <= stat_nxt;
            mux_sel_b <= sel_b_nxt;
        end
    end

    // serial slave: edge and condition detection on filtered pins
    logic scl_d_r, sda_d_r;
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = pin_f_r.scl & ~scl_d_r;
    assign scl_fall = ~pin_f_r.scl & scl_d_r;
    assign start_c = pin_f_r.scl & scl_d_r & sda_d_r & ~pin_f_r.sda;
    assign stop_c = pin_f_r.scl & scl_d_r & ~sda_d_r & pin_f_r.sda;

    // strap decode: following the data line at start means tied to it
    logic [6:0] my_addr_r, my_addr_nxt;
    always_comb begin
        my_addr_nxt = my_addr_r;
        if (start_c) begin
            if (pin_f_r.strap) begin
                my_addr_nxt = `VIAS_ADDR_STRAP_HI;
            end else if (strap_prev_r) begin
                my_addr_nxt = `VIAS_ADDR_STRAP_SDA;
            end else begin
                my_addr_nxt = `VIAS_ADDR_STRAP_LO;
            end
        end
    end

    vias_i2c_type st_r, st_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic full_r, full_nxt, rw_r, rw_nxt, oe_nxt, rd_stat;
    logic [3:0] ptr_r, ptr_nxt;
    logic [7:0] rd_byte;
    // read mux: status is live, the rest is storage
    assign rd_byte = (ptr_r == `VIAS_REG_STATUS) ? {5'h00, stat_r} : regs_r[ptr_r];
    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        cnt_nxt = cnt_r;
        full_nxt = full_r;
        rw_nxt = rw_r;
        ptr_nxt = ptr_r;
        oe_nxt = sda_oe;
        rd_stat = 1'b0;
        regs_nxt = regs_r;
        // sample on rising clock edges
        if (scl_rise && st_r != VIAS_IDLE) begin
            sh_nxt = {sh_r[6:0], pin_f_r.sda};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
                full_nxt = 1'b1;
            end
            if (st_r == VIAS_RACK && pin_f_r.sda) begin
                st_nxt = VIAS_IDLE; // master nack ends the read
            end
        end
        // act on falling clock edges, so data only moves while the clock is low
        if (scl_fall) begin
            case (st_r)
                VIAS_ADDR: begin
                    if (full_r) begin
                        full_nxt = 1'b0;
                        cnt_nxt = 3'h0;
                        if (sh_r[7:1] == my_addr_r) begin
                            rw_nxt = sh_r[0];
                            st_nxt = VIAS_AACK;
                            oe_nxt = 1'b1;
                        end else begin
                            st_nxt = VIAS_IDLE;
                        end
                    end
                end
                VIAS_AACK, VIAS_RACK: begin
                    cnt_nxt = 3'h0;
                    full_nxt = 1'b0;
                    if (rw_r) begin
                        tx_nxt = rd_byte;
                        rd_stat = (ptr_r == `VIAS_REG_STATUS);
                        ptr_nxt = ptr_r + 4'h1;
                        oe_nxt = ~rd_byte[7];
                        st_nxt = VIAS_RD;
                    end else begin
                        oe_nxt = 1'b0;
                        st_nxt = VIAS_PTR;
                    end
                end
                VIAS_PTR: begin
                    if (full_r) begin
                        full_nxt = 1'b0;
                        ptr_nxt = sh_r[3:0];
                        oe_nxt = 1'b1;
                        st_nxt = VIAS_PACK;
                    end
                end
                VIAS_PACK, VIAS_WACK: begin
                    oe_nxt = 1'b0;
                    cnt_nxt = 3'h0;
                    st_nxt = VIAS_WR;
                end
                VIAS_WR: begin
                    if (full_r) begin
                        full_nxt = 1'b0;
                        if (ptr_r != `VIAS_REG_STATUS) begin
                            regs_nxt[ptr_r] = sh_r;
                        end
                        ptr_nxt = ptr_r + 4'h1;
                        oe_nxt = 1'b1;
                        st_nxt = VIAS_WACK;
                    end
                end
                VIAS_RD: begin
                    if (full_r) begin
                        oe_nxt = 1'b0;
                        st_nxt = VIAS_RACK;
                    end else begin
                        oe_nxt = ~tx_r[3'h7 - cnt_r];
                    end
                end
                VIAS_IDLE: oe_nxt = 1'b0;
                default: st_nxt = VIAS_IDLE;
            endcase
        end
        // bus conditions override everything
        if (start_c) begin
            st_nxt = VIAS_ADDR;
            cnt_nxt = 3'h0;
            full_nxt = 1'b0;
            oe_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt = VIAS_IDLE;
            oe_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            my_addr_r <= `VIAS_ADDR_STRAP_HI;
            st_r <= VIAS_IDLE;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            cnt_r <= 3'h0;
            full_r <= 1'b0;
            rw_r <= 1'b0;
            ptr_r <= 4'h0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            for (int i = 0; i < NREG; i++) begin
                regs_r[i] <= (i == `VIAS_REG_INPUT_CHOICE_FIELD) ? `VIAS_CFG_RESET : `VIAS_REG_RESET;
            end
        end else begin
            scl_d_r <= pin_f_r.scl;
            sda_d_r <= pin_f_r.sda;
            my_addr_r <= my_addr_nxt;
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
            rw_r <= rw_nxt;
            ptr_r <= ptr_nxt;
            sda_oe <= oe_nxt;
            sda_o <= 1'b0;
            regs_r <= regs_nxt;
        end
    end

    // settings bus mirrors storage; status slot carries zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            settings <= '0;
        end else begin
            for (int i = 0; i < NREG; i++) begin
                settings[i*8 +: 8] <= (i == 0) ? 8'h00 : regs_r[i];
            end
        end
    end

    // interrupt: a change arms it once; a change in the clearing cycle wins over the read
    logic irq_nxt;
    always_comb begin
        irq_nxt = irq_n_oe;
        if (rd_stat) begin
            irq_nxt = 1'b0;
        end
        if (stat_nxt != stat_r && !cfg[`VIAS_CFG_IRQ_MASK] && (!irq_n_oe || rd_stat)) begin
            irq_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_n_oe <= 1'b0;
            irq_n_o <= 1'b0;
        end else begin
            irq_n_oe <= irq_nxt;
            irq_n_o <= 1'b0;
        end
    end
endmodule : vias_top

// File: video_input_activity_select_tb_top.sv
// video_input_activity_select_tb_top: self-checking bench for vias_top.
// assumes vias_i2c_host on the serial port and a pull-up on the data line.
`timescale 1ns/1ps
`include "vias_defs.svh"
module video_input_activity_select_tb_top;
    import vias_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic strap_v = 1'b1;
    logic strap_sda = 1'b0;
    logic ca = 1'b0, cb = 1'b0, sa = 1'b0, sb = 1'b0, sleep_mode = 1'b0;
    logic conv_activity = 1'b0;
    logic esel, a;
    logic [7:0] q, d;
    logic [6:0] dev;
    logic [6:0] adr [3] = '{`VIAS_ADDR_STRAP_HI, `VIAS_ADDR_STRAP_LO, `VIAS_ADDR_STRAP_SDA};
    logic [5:0] steps [6] = '{6'h00, 6'h12, 6'h15, 6'h1F, 6'h0A, 6'h31};
    wire scl, host_dn, sda, strap;
    logic sda_o, sda_oe, mux_sel_b, irq_n_o, irq_n_oe;
    logic [127:0] settings;
    int fail_count = 0, total_checks = 0, cyc = 0;
    // open-drain data line; strap may be tied onto it
    assign sda = !(host_dn | sda_oe);
    assign strap = strap_sda ? sda : strap_v;
    vias_top i_dut (
        .clk, .sys_rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
        .slave_addr_strap(strap), .conv_activity, .slice_video_in_a(sa),
        .slice_video_in_b(sb), .sleep_mode, .mux_sel_b, .settings, .irq_n_o, .irq_n_oe
    );
    vias_i2c_host i_host (.clk, .sda, .scl, .sda_dn(host_dn));
    always #12.5 clk = ~clk;
    // converter sees only the input the mux passes
    always @(negedge clk) conv_activity <= mux_sel_b ? cb : ca;
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : check
    // register write; ea is the expected level of the last ninth bit
    task automatic wr(input logic [3:0] p, input logic [7:0] v, input logic ea);
        i_host.start();
        i_host.xfer({dev, 1'b0}, 1'b1, q, a);
        i_host.xfer({4'h0, p}, 1'b1, q, a);
        i_host.xfer(v, 1'b1, q, a);
        i_host.stop();
        check("ack", {7'h00, ea}, {7'h00, a});
    endtask : wr
    task automatic rd(input logic [3:0] p, output logic [7:0] v);
        i_host.start();
        i_host.xfer({dev, 1'b0}, 1'b1, q, a);
        i_host.xfer({4'h0, p}, 1'b1, q, a);
        i_host.start();
        i_host.xfer({dev, 1'b1}, 1'b1, q, a);
        i_host.xfer(8'hFF, 1'b1, v, a);
        i_host.stop();
    endtask : rd
    // {sleep, slicer b, slicer a, converter b, converter a}, then let it settle
    task automatic drive(input logic [4:0] v);
        {sleep_mode, sb, sa, cb, ca} = v;
        repeat (20) @(negedge clk);
    endtask : drive
    // reference status: slicers in sleep or for the undecoded input
    function automatic vias_status_type exp_st(input logic s);
        return '{s, (sleep_mode | !s) ? sb : cb, (sleep_mode | s) ? sa : ca};
    endfunction : exp_st
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    initial begin
        q = 8'($urandom(7));
        dev = adr[0];
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        check("mux", 8'h00, {7'h00, mux_sel_b});
        check("irq", 8'h00, {7'h00, irq_n_oe});
        // each strap answers on its own address and not on the next strap's address
        for (int i = 0; i < 3; i++) begin
            strap_v = (i != 1);
            strap_sda = (i == 2);
            d = 8'($urandom);
            dev = adr[i];
            wr(4'h3, d, 1'b0);
            dev = adr[(i + 1) % 3];
            wr(4'h3, ~d, 1'b1);
            check("reg3", d, settings[31:24]);
        end
        strap_v = 1'b1;
        strap_sda = 1'b0;
        dev = adr[0];
        // pointer wraps past 0x0F and status takes no write
        i_host.start();
        i_host.xfer({dev, 1'b0}, 1'b1, q, a);
        i_host.xfer(8'h0F, 1'b1, q, a);
        i_host.xfer(8'hA5, 1'b1, q, a);
        i_host.xfer(8'h5A, 1'b1, q, a);
        i_host.xfer(8'h3C, 1'b1, q, a);
        i_host.stop();
        check("regF", 8'hA5, settings[127:120]);
        check("reg0", 8'h00, settings[7:0]);
        check("reg1", 8'h3C, settings[15:8]);
        // manual choice with random activity on every source
        for (int i = 0; i < 8; i++) begin
            esel = i[1];
            wr(4'h9, {7'h00, esel}, 1'b0);
            drive(5'($urandom));
            rd(4'h0, q);
            check("status", {5'h00, exp_st(esel)}, q);
            check("mux", {7'h00, esel}, {7'h00, mux_sel_b});
        end
        // automatic pick through idle, both, only two, sticky two, back, sleep
        wr(4'h9, 8'h02, 1'b0);
        foreach (steps[k]) begin
            esel = steps[k][0];
            drive(steps[k][5:1]);
            rd(4'h0, q);
            check("auto st", {5'h00, exp_st(esel)}, q);
            check("auto mux", {7'h00, esel}, {7'h00, mux_sel_b});
        end
        // interrupt raised, held through more changes, cleared by a read, masked
        wr(4'h9, 8'h00, 1'b0);
        drive(5'h00);
        rd(4'h0, q);
        check("irq", 8'h00, {7'h00, irq_n_oe});
        drive(5'h01);
        check("irq", 8'h01, {7'h00, irq_n_oe});
        drive(5'h09);
        check("irq", 8'h01, {7'h00, irq_n_oe});
        rd(4'h0, q);
        check("irq", 8'h00, {7'h00, irq_n_oe});
        wr(4'h9, 8'h80, 1'b0);
        drive(5'h00);
        check("irq", 8'h00, {7'h00, irq_n_oe});
        end_of_test();
    end
endmodule : video_input_activity_select_tb_top
